// ### otp_sec_pkg.sv
// Purpose: Shared constants for the one-time-programmable store and its
//   security configuration word.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets of the APB registers are local to this block.
package otp_sec_pkg;
  // Store geometry.
  localparam int unsigned sector_count = 4;
  localparam int unsigned rows_per_sector = 512;
  localparam int unsigned word_width = 32;
  localparam int unsigned row_bits = 9;
  localparam int unsigned sector_bits = 2;
  localparam int unsigned addr_bits = 11;

  // Security word bit positions.
  localparam int unsigned sec_jtag_off = 0;
  localparam int unsigned sec_link_off = 1;
  localparam int unsigned sec_boot_otp = 5;
  localparam int unsigned sec_redund = 7;
  localparam int unsigned sec_lock_lo = 8;
  localparam int unsigned sec_master = 12;
  localparam int unsigned sec_jtag_otp_off = 13;
  localparam int unsigned sec_debug_off = 14;
  localparam int unsigned sec_gp_lo = 15;
  localparam int unsigned sec_gp_hi = 21;
  localparam int unsigned sec_uce_lo = 22;
  localparam int unsigned sec_uce_hi = 31;

  // Resource identifiers of the programming ports.
  localparam logic [23:0] rid_addr = 24'h100200;
  localparam logic [23:0] rid_data = 24'h200100;
  localparam logic [23:0] rid_ctrl = 24'h100300;

  // Control port command codes.
  localparam logic [15:0] cmd_prog = 16'h0001;
  localparam logic [15:0] cmd_prog_sec = 16'h0002;

  // Row of the store that holds the security word.
  localparam logic [10:0] sec_row = 11'h7ff;

  // APB register byte offsets.
  localparam logic [7:0] reg_addr = 8'h00;
  localparam logic [7:0] reg_data = 8'h04;
  localparam logic [7:0] reg_ctrl = 8'h08;
  localparam logic [7:0] reg_sec = 8'h0c;
  localparam logic [7:0] reg_status = 8'h10;
  localparam logic [7:0] reg_rdata = 8'h14;

  // Status bit positions.
  localparam int unsigned st_ready = 0;
  localparam int unsigned st_busy = 1;
  localparam int unsigned st_refused = 2;
  localparam int unsigned st_boot_done = 3;

  // Sequencer states.
  typedef enum logic [2:0] {
    st_load_sec, st_copy, st_idle, st_prog, st_done
  } seq_t;
endpackage : otp_sec_pkg

// ### otp_array.sv
// Purpose: Storage for the one-time-programmable words.
// Assumes: Programming can only set bits; a write ORs into the word.
// Notes: Read data is registered, one cycle after the address.
module otp_array
  import otp_sec_pkg::*;
#(
  parameter int unsigned depth = sector_count * rows_per_sector,
  parameter int unsigned width = word_width
) (
  // Clock.
  input wire logic clock,
  // Read port.
  input wire logic [addr_bits-1:0] rd_addr,
  output logic [width-1:0] rd_data,
  // Program port.
  input wire logic wr_en,
  input wire logic [addr_bits-1:0] wr_addr,
  input wire logic [width-1:0] wr_data
);
  // A blank store reads all zero until a fuse is blown; the start value
  // stands in for an unprogrammed part.
  logic [width-1:0] mem [depth] = '{default: '0};

  // Fuses only blow: OR keeps old ones set.
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= mem[wr_addr] | wr_data;
    end
  end

  // Registered read.
  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end
endmodule : otp_array

// ### otp_security_control.sv
// Purpose: Tile security controller around a one-time-programmable store.
// Assumes: Port writes from the core and JTAG requests are on clock.
// Notes: Programming ports are also reachable over APB.
//
// Added by the designer: the APB interface to the registers and the register offsets.
module otp_security_control
  import otp_sec_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core resource port writes.
  input wire logic res_wr,
  input wire logic [23:0] res_id,
  input wire logic [31:0] res_data,
  // Copy-out stream to SRAM.
  output logic copy_valid,
  output logic [addr_bits-1:0] copy_addr,
  output logic [31:0] copy_data,
  output logic core_run,
  // JTAG requests.
  input wire logic jtag_tile_req,
  input wire logic jtag_otp_req,
  input wire logic link_req,
  output logic jtag_tile_grant,
  output logic jtag_otp_grant,
  output logic link_grant,
  // Security outputs.
  output logic boot_from_otp,
  output logic redundancy_en,
  output logic debug_pin_en,
  output logic [6:0] gp_value,
  output logic [9:0] user_code_extension
);
  logic rst_meta_q, rst_sync_q;
  seq_t state_q;
  logic [addr_bits-1:0] ptr_q;
  logic rd_pend_q;
  logic [31:0] sec_q;
  logic [15:0] addr_q;
  logic [31:0] data_q;
  logic [31:0] rdata_q;
  logic refused_q;
  logic [31:0] rd_word;
  logic wr_en;
  logic [addr_bits-1:0] rd_addr;
  logic cmd_valid;
  logic [15:0] cmd;
  logic cmd_ok;
  logic apb_wr;
  logic apb_rd;
  logic mapped;

  // Lock check for a row address; locked sectors and master lock refuse.
  function automatic logic prog_allowed(input logic [31:0] s,
                                        input logic [addr_bits-1:0] a);
    logic [sector_bits-1:0] sec;
    sec = a[addr_bits-1 -: sector_bits];
    return !s[sec_master] && !s[sec_lock_lo + 32'(sec)];
  endfunction : prog_allowed

  // Reset release through two flops; assertion stays asynchronous.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign mapped = (paddr == reg_addr) || (paddr == reg_data) ||
                  (paddr == reg_ctrl) || (paddr == reg_sec) ||
                  (paddr == reg_status) || (paddr == reg_rdata);

  // Address and data ports, from core by resource id or from APB.
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      addr_q <= 16'h0000;
      data_q <= 32'h00000000;
    end else begin
      if (res_wr && res_id == rid_addr) begin
        addr_q <= res_data[15:0];
      end else if (apb_wr && paddr == reg_addr) begin
        addr_q <= pwdata[15:0];
      end
      if (res_wr && res_id == rid_data) begin
        data_q <= res_data;
      end else if (apb_wr && paddr == reg_data) begin
        data_q <= pwdata;
      end
    end
  end

  // Control command, from core port or APB; core wins a tie.
  always_comb begin
    cmd_valid = 1'b0;
    cmd = 16'h0000;
    if (res_wr && res_id == rid_ctrl) begin
      cmd_valid = 1'b1;
      cmd = res_data[15:0];
    end else if (apb_wr && paddr == reg_ctrl) begin
      cmd_valid = 1'b1;
      cmd = pwdata[15:0];
    end
  end

  // Row programming goes to the addressed row; security programming to
  // the reserved row, guarded only by the master lock.
  always_comb begin
    cmd_ok = 1'b0;
    if (cmd == cmd_prog) begin
      cmd_ok = prog_allowed(sec_q, addr_q[addr_bits-1:0]);
    end else if (cmd == cmd_prog_sec) begin
      cmd_ok = !sec_q[sec_master];
    end
  end
  assign wr_en = (state_q == st_idle) && cmd_valid && cmd_ok;

  // Read pointer: sequencer during boot, programming row later.
  assign rd_addr = (state_q == st_idle) ? addr_q[addr_bits-1:0] :
                   (state_q == st_load_sec) ? sec_row : ptr_q;

  otp_array u_array (
    .clock(clock),
    .rd_addr(rd_addr),
    .rd_data(rd_word),
    .wr_en(wr_en),
    .wr_addr((cmd == cmd_prog_sec) ? sec_row : addr_q[addr_bits-1:0]),
    .wr_data(data_q)
  );

  // Boot sequencer: security word first, then copy, then release core.
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= st_load_sec;
      ptr_q <= 11'h000;
      rd_pend_q <= 1'b0;
    end else begin
      case (state_q)
        st_load_sec: begin
          rd_pend_q <= 1'b1;
          if (rd_pend_q) begin
            state_q <= st_copy;
            rd_pend_q <= 1'b0;
          end
        end
        st_copy: begin
          // Two cycles a row, so the registered read stays in step with
          // the pointer that the copy stream reports.
          rd_pend_q <= !rd_pend_q;
          if (rd_pend_q) begin
            if (ptr_q == sec_row - 11'h001) begin
              state_q <= st_done;
            end else begin
              ptr_q <= ptr_q + 11'h001;
            end
          end
        end
        // One cycle so the last copied word shows before the core runs.
        st_done: state_q <= st_idle;
        st_idle: state_q <= st_idle;
        default: state_q <= st_idle;
      endcase
    end
  end

  // Security word latched from the store, and kept in step after a
  // security programming of the reserved row; only ORs so bits never fall.
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sec_q <= 32'h00000000;
    end else if (state_q == st_load_sec && rd_pend_q) begin
      sec_q <= rd_word;
    end else if (wr_en && cmd == cmd_prog_sec) begin
      sec_q <= sec_q | data_q;
    end
  end

  // Copy stream; the word a cycle after its address was presented.
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      copy_valid <= 1'b0;
      copy_addr <= 11'h000;
      copy_data <= 32'h00000000;
    end else begin
      copy_valid <= (state_q == st_copy) && rd_pend_q;
      copy_addr <= ptr_q;
      copy_data <= rd_word;
    end
  end

  // Refusal sticky flag: set wins over a clear in the same cycle.
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      refused_q <= 1'b0;
    end else if (state_q == st_idle && cmd_valid && !cmd_ok) begin
      refused_q <= 1'b1;
    end else if (apb_wr && paddr == reg_status && pwdata[st_refused]) begin
      refused_q <= 1'b0;
    end
  end

  // Grants and security outputs from the latched word.
  always_comb begin
    core_run = (state_q == st_idle);
    jtag_tile_grant = jtag_tile_req && !sec_q[sec_jtag_off];
    link_grant = link_req && !sec_q[sec_link_off];
    jtag_otp_grant = jtag_otp_req && !sec_q[sec_jtag_off] &&
                     !sec_q[sec_jtag_otp_off];
    boot_from_otp = sec_q[sec_boot_otp];
    redundancy_en = sec_q[sec_redund];
    debug_pin_en = !sec_q[sec_debug_off];
    gp_value = sec_q[sec_gp_hi:sec_gp_lo];
    user_code_extension = sec_q[sec_uce_hi:sec_uce_lo];
  end

  // Holds the store word at the programming address for APB readback.
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= 32'h00000000;
    end else if (state_q == st_idle) begin
      rdata_q <= rd_word;
    end
  end

  // APB answers in the access phase with no wait; unmapped reads zero
  // and flags an error.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        reg_addr: prdata <= {16'h0000, addr_q};
        reg_data: prdata <= data_q;
        reg_sec: prdata <= sec_q;
        reg_status: prdata <= {28'h0000000, state_q == st_done,
          refused_q, state_q != st_idle, state_q == st_idle};
        reg_rdata: prdata <= rdata_q;
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule : otp_security_control

// ### otp_security_control_asserts.sv
// Purpose: Port checks for the tile security controller.
// Assumes: One clock domain; rst_b low clears the controller state, not the store.
// Notes: Bound to the controller below the module.
module otp_security_control_asserts
  import otp_sec_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // APB answer.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Boot copy and run.
  input wire logic copy_valid,
  input wire logic [addr_bits-1:0] copy_addr,
  input wire logic core_run,
  // Access gates.
  input wire logic jtag_tile_req,
  input wire logic link_req,
  input wire logic jtag_tile_grant,
  input wire logic jtag_otp_grant,
  input wire logic link_grant,
  // Security outputs.
  input wire logic boot_from_otp,
  input wire logic debug_pin_en,
  input wire logic [6:0] gp_value
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // A setup cycle followed by its access cycle.
  sequence apb_access;
    psel && !penable ##1 psel && penable;
  endsequence

  a_apb_zero_wait: assert property (apb_access |-> pready)
    else $error("APB access not answered at once");
  a_tile_gate: assert property (
    jtag_tile_grant |-> jtag_tile_req)
    else $error("Tile grant without request");
  a_link_gate: assert property (link_grant |-> link_req)
    else $error("Link grant without request");
  a_store_gate: assert property (
    jtag_otp_grant && jtag_tile_req |-> jtag_tile_grant)
    else $error("Store grant while tile access is barred");
  a_copy_before_run: assert property (
    copy_valid |-> !core_run)
    else $error("Copy seen after the core runs");
  a_copy_skips_sec: assert property (
    copy_valid |-> copy_addr != sec_row)
    else $error("Security row copied out");
  a_run_holds: assert property (core_run |=> core_run)
    else $error("Core run dropped");
  a_boot_sticky: assert property (
    boot_from_otp && core_run |=> boot_from_otp)
    else $error("Secure boot cleared");
  a_debug_sticky: assert property (
    !debug_pin_en |=> !debug_pin_en)
    else $error("Debug pin came back");
  a_gp_sticky: assert property (
    (gp_value & $past(gp_value)) == $past(gp_value))
    else $error("General purpose bit cleared");
endmodule : otp_security_control_asserts

bind otp_security_control otp_security_control_asserts u_asserts (
  .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pready(pready), .copy_valid(copy_valid), .copy_addr(copy_addr),
  .core_run(core_run), .jtag_tile_req(jtag_tile_req),
  .link_req(link_req), .jtag_tile_grant(jtag_tile_grant),
  .jtag_otp_grant(jtag_otp_grant), .link_grant(link_grant),
  .boot_from_otp(boot_from_otp), .debug_pin_en(debug_pin_en),
  .gp_value(gp_value)
);

// ### core_port_model.sv
// Purpose: Behavioural processor core writing the programming ports.
// Assumes: One strobe cycle per port write.
// Notes: Idle lines show the inverse so stale values are never reused.
module core_port_model
  import otp_sec_pkg::*;
(
  // Clock.
  input wire logic clock,
  // Resource port writes.
  output logic res_wr,
  output logic [23:0] res_id,
  output logic [31:0] res_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    res_wr = 1'b0;
    res_id = 24'h0;
    res_data = 32'h0;
  end

  // One port write; the strobe drops so the next write is a new one.
  task put(input logic [23:0] id, input logic [31:0] d);
    @(posedge clock);
    res_wr <= 1'b1;
    res_id <= id;
    res_data <= d;
    @(posedge clock);
    res_wr <= 1'b0;
    res_id <= ~id;
    res_data <= ~d;
  endtask : put

  // Address, data, then command, each on its fixed port.
  task prog_row(input logic [10:0] a, input logic [31:0] d,
    input logic [15:0] cmd);
    put(rid_addr, {21'h0, a});
    put(rid_data, d);
    put(rid_ctrl, {16'h0, cmd});
  endtask : prog_row
endmodule : core_port_model

// ### otp_security_control_test.sv
// Purpose: Self-checking bench for the tile security controller.
// Assumes: APB answers with zero wait; boot copy runs about 4100 cycles.
// Notes: Rows go in by the core ports and by APB alike.
module otp_security_control_test
  import otp_sec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_b, psel, penable, pwrite, pready, pslverr, res_wr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, res_data, copy_data, q;
  logic [23:0] res_id;
  logic copy_valid, core_run, jtag_tile_req, jtag_otp_req, link_req;
  logic jtag_tile_grant, jtag_otp_grant, link_grant;
  logic boot_from_otp, redundancy_en, debug_pin_en;
  logic [addr_bits-1:0] copy_addr;
  logic [6:0] gp_value;
  logic [9:0] user_code_extension;
  int n_errors = 0;
  int n_tests = 0;
  int n_copy = 0;
  logic [31:0] copy_row5;
  localparam int unsigned n_rows = sector_count * rows_per_sector;
  // Bits 0,1,5,7,8,13,14, value 55 at 21:15, 2a5 at 31:22.
  localparam logic [31:0] sec_a = 32'ha96ae1a3;

  // A 4 ns clock.
  always #2 clock = ~clock;

  otp_security_control u_otp_security_control (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .res_wr(res_wr), .res_id(res_id),
    .res_data(res_data), .copy_valid(copy_valid), .copy_addr(copy_addr),
    .copy_data(copy_data), .core_run(core_run),
    .jtag_tile_req(jtag_tile_req), .jtag_otp_req(jtag_otp_req),
    .link_req(link_req), .jtag_tile_grant(jtag_tile_grant),
    .jtag_otp_grant(jtag_otp_grant), .link_grant(link_grant),
    .boot_from_otp(boot_from_otp), .redundancy_en(redundancy_en),
    .debug_pin_en(debug_pin_en), .gp_value(gp_value),
    .user_code_extension(user_code_extension));
  core_port_model u_core_port_model (
    .clock(clock), .res_wr(res_wr), .res_id(res_id), .res_data(res_data));

  task final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the ready edge.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task aprog(input logic [10:0] a, input logic [31:0] d,
    input logic [15:0] cmd);
    apb(1'b1, reg_addr, {21'h0, a});
    apb(1'b1, reg_data, d);
    apb(1'b1, reg_ctrl, {16'h0, cmd});
  endtask : aprog

  // The first read covers the store's read latency.
  task row(input logic [10:0] a, input logic [31:0] exp);
    apb(1'b1, reg_addr, {21'h0, a});
    apb(1'b0, reg_rdata, 32'h0);
    apb(1'b0, reg_rdata, 32'h0);
    chk("store word", exp, q);
  endtask : row

  // Counts the boot copy words and keeps the one for row 5.
  always @(posedge clock) begin
    if (copy_valid === 1'b1) begin
      n_copy <= n_copy + 1;
      if (copy_addr == 11'h005) begin
        copy_row5 <= copy_data;
      end
    end
  end

  // Cuts a hang short well beyond boot plus the tests.
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    final_report;
  end

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    jtag_tile_req = 1'b1;
    jtag_otp_req = 1'b1;
    link_req = 1'b1;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk("grants", 32'h7, {29'h0, jtag_tile_grant, jtag_otp_grant,
      link_grant});
    apb(1'b0, reg_status, 32'h0);
    chk("status", 32'h2, q);
    while (core_run !== 1'b1) @(posedge clock);
    chk("copy count", n_rows - 1, n_copy);
    apb(1'b0, reg_sec, 32'h0);
    chk("security", 32'h0, q);
    apb(1'b0, reg_status, 32'h0);
    chk("status", 32'h1, q);
    $display("Test reset done");
    u_core_port_model.prog_row(11'h005, 32'hf0,
      cmd_prog);
    aprog(11'h005, 32'hf00, cmd_prog);
    row(11'h005, 32'hff0);
    aprog(11'h603, 32'h5a, cmd_prog);
    row(11'h603, 32'h5a);
    $display("Test programming done");
    aprog(sec_row, sec_a, cmd_prog_sec);
    apb(1'b0, reg_sec, 32'h0);
    chk("security", sec_a, q);
    row(sec_row, sec_a);
    chk("grants", 32'h0, {29'h0, jtag_tile_grant, jtag_otp_grant,
      link_grant});
    chk("boot", 32'h6, {29'h0, boot_from_otp, redundancy_en,
      debug_pin_en});
    chk("gp", 32'h55, {25'h0, gp_value});
    chk("user code", 32'h2a5, {22'h0, user_code_extension});
    $display("Test security word done");
    u_core_port_model.prog_row(11'h005, 32'h1, cmd_prog);
    row(11'h005, 32'hff0);
    apb(1'b0, reg_status, 32'h0);
    chk("status", 32'h5, q);
    apb(1'b1, reg_status, 32'h4);
    apb(1'b0, reg_status, 32'h0);
    chk("status", 32'h1, q);
    aprog(11'h205, 32'h3c, cmd_prog);
    row(11'h205, 32'h3c);
    $display("Test sector lock done");
    aprog(sec_row, 32'h1000, cmd_prog_sec);
    aprog(11'h205, 32'hc0, cmd_prog);
    row(11'h205, 32'h3c);
    aprog(sec_row, 32'h4, cmd_prog_sec);
    apb(1'b0, reg_sec, 32'h0);
    chk("security", sec_a | 32'h1000, q);
    apb(1'b0, 8'h40, 32'h0);
    chk("slave error", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, q);
    $display("Test master lock done");
    // A second power-up: the store keeps its words, the register reloads.
    rst_b <= 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk("core run", 32'h0, {31'h0, core_run});
    while (core_run !== 1'b1) @(posedge clock);
    chk("copy count", 2 * (n_rows - 1), n_copy);
    chk("copied row", 32'hff0, copy_row5);
    apb(1'b0, reg_sec, 32'h0);
    chk("security", sec_a | 32'h1000, q);
    chk("grants", 32'h0, {29'h0, jtag_tile_grant, jtag_otp_grant,
      link_grant});
    $display("Test second boot done");
    final_report;
  end
endmodule : otp_security_control_test
